// ==== rtad_checker.sv ====
/*
 Checker for the two-wire link joining the master end and the device end.
 Assumes hclk samples the resolved lines and the divider keeps its reset value.
*/
`timescale 1ns/100ps
module rtad_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic scl_q_ff;
   logic sda_q_ff;
   logic [3:0] bit_cnt_ff;
   logic [3:0] nxt_bit_cnt;
   // Line events seen at hclk
   wire start_w = scl && scl_q_ff && sda_q_ff && !sda;
   wire stop_w = scl && scl_q_ff && !sda_q_ff && sda;
   wire rise_w = scl && !scl_q_ff;
   wire cnt_wrap_w = (bit_cnt_ff == 4'h8);
   // Pulse number 1 to 9 in a frame; the pulse after the ninth opens a new frame
   assign nxt_bit_cnt = (start_w || stop_w) ? 4'h0 :
                        !rise_w ? bit_cnt_ff : (bit_cnt_ff == 4'h9) ? 4'h1 : bit_cnt_ff + 4'h1;
   // Line history and frame counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         bit_cnt_ff <= 4'h0;
      end else begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
         bit_cnt_ff <= nxt_bit_cnt;
      end
   end
   sequence s_dev_low_rise;
      rise_w && sda_d_oe;
   endsequence
   sequence s_nack_rise;
      rise_w && cnt_wrap_w && sda;
   endsequence
   property p_open_drain;
      !(sda_d_oe && sda_d_o) && !(sda_m_oe && sda_m_o) && !(scl_oe && scl_o);
   endproperty
   property p_start_master;
      start_w |-> sda_m_oe && !sda_d_oe;
   endproperty
   property p_stop_frame;
      stop_w |-> bit_cnt_ff <= 4'h1 && !sda_d_oe;
   endproperty
   property p_start_frame;
      start_w |-> bit_cnt_ff <= 4'h1;
   endproperty
   property p_dev_stable;
      $changed(sda_d_oe) |-> !scl && !scl_q_ff;
   endproperty
   property p_ack_hold;
      s_dev_low_rise |=> sda_d_oe [*3];
   endproperty
   property p_scl_high;
      rise_w |-> scl [*3];
   endproperty
   property p_no_fight;
      scl |-> !(sda_m_oe && sda_d_oe);
   endproperty
   property p_nack_release;
      s_nack_rise |=> !sda_d_oe [*8];
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("Line driven high");
   a_start_master: assert property (p_start_master)
      else $error("Start not made by master");
   a_stop_frame: assert property (p_stop_frame)
      else $error("Stop inside a byte frame");
   a_start_frame: assert property (p_start_frame)
      else $error("Start inside a byte frame");
   a_dev_stable: assert property (p_dev_stable)
      else $error("Device data changed while clock high");
   a_ack_hold: assert property (p_ack_hold)
      else $error("Device low level not held through clock high");
   a_scl_high: assert property (p_scl_high)
      else $error("Clock high period too short");
   a_no_fight: assert property (p_no_fight)
      else $error("Both ends pull data while clock high");
   a_nack_release: assert property (p_nack_release)
      else $error("Device drives data after missing acknowledge");
endmodule : rtad_checker

// ==== rtad_dev.sv ====
/*
 Device end: two-wire slave front end with control-byte and address decode.
 Assumes the link pins are asynchronous to hclk and pass two flip-flops.
 The memory side is a simple byte port on hclk.
*/
`timescale 1ns/100ps
module rtad_dev (
   input wire logic hclk,
   input wire logic hresetn,
   rtad_link_if.device link,
   input wire logic on_backup,
   input wire logic ee_busy,
   output logic mem_wr_ff,
   output logic mem_rd_ff,
   output logic mem_ee_ff,
   output logic [7:0] mem_addr_ff,
   output logic [7:0] mem_wdata_ff,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] protect_ff
);
   import rtad_pkg::*;

   typedef enum logic [4:0] {
      RTAD_IDLE = 5'b00001, RTAD_RECV = 5'b00010, RTAD_ACK = 5'b00100,
      RTAD_SEND = 5'b01000, RTAD_MACK = 5'b10000
   } rtad_dstate_t;

   // Window check for a byte address in either space
   function automatic logic rtad_in_range(input logic ee, input logic [7:0] a);
      if (ee) begin
         rtad_in_range = (a <= RTAD_EE_LAST) || (a >= RTAD_PROT_BASE && a <= RTAD_PROT_LAST)
                         || (a == RTAD_PROTECT_REG);
      end else begin
         rtad_in_range = (a <= RTAD_RT_LAST);
      end
   endfunction : rtad_in_range

   // clock groups ascend and stay below the SRAM window
   if (!(RTAD_TIME_BASE < RTAD_CFG_BASE && RTAD_CFG_BASE < RTAD_ALM0_BASE
         && RTAD_ALM0_BASE < RTAD_ALM1_BASE && RTAD_ALM1_BASE < RTAD_STAMP_BASE
         && RTAD_STAMP_BASE < RTAD_SRAM_BASE)) begin : g_grp_chk
      $error("Clock register groups misplaced");
   end

   logic [1:0] scl_s_ff, sda_s_ff, bak_s_ff;
   logic scl_d_ff, sda_d_ff;
   rtad_dstate_t st_ff, nxt_st;
   logic [7:0] sh_ff, nxt_sh;
   logic [3:0] bit_ff, nxt_bit;
   logic [1:0] byte_ff, nxt_byte;
   logic ee_ff, nxt_ee, rd_ff, nxt_rd, ack_ff, nxt_ack, drv_ff, nxt_drv;
   logic [7:0] ptr_ff, nxt_ptr;
   logic nxt_wr, nxt_rdq;

   // Two-stage synchronisers, then one delay stage for edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_s_ff <= 2'h3;
         sda_s_ff <= 2'h3;
         bak_s_ff <= 2'h0;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_s_ff <= {scl_s_ff[0], link.scl};
         sda_s_ff <= {sda_s_ff[0], link.sda};
         bak_s_ff <= {bak_s_ff[0], on_backup};
         scl_d_ff <= scl_s_ff[1];
         sda_d_ff <= sda_s_ff[1];
      end
   end

   wire scl_q = scl_s_ff[1];
   wire sda_q = sda_s_ff[1];
   wire on_bak_q = bak_s_ff[1]; // Supply flag comes from another domain
   wire scl_rise = scl_q && !scl_d_ff;
   wire scl_fall = !scl_q && scl_d_ff;
   wire start_ev = scl_q && scl_d_ff && !sda_q && sda_d_ff;
   wire stop_ev = scl_q && scl_d_ff && sda_q && !sda_d_ff;
   wire [7:0] rx_byte = {sh_ff[6:0], sda_q};
   // control code decode, chip select ones
   wire code_ee = rx_byte[7:4] == RTAD_CODE_EE;
   wire code_rt = rx_byte[7:4] == RTAD_CODE_RT;
   wire addr_ok = (code_ee || code_rt) && rx_byte[3:1] == RTAD_CHIP_SEL;
   // no ack to EEPROM while programming
   wire ctrl_ack = addr_ok && !(code_ee && ee_busy);
   wire prot_hit = ee_ff && ptr_ff == RTAD_PROTECT_REG;

   // Link state machine
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_bit = bit_ff;
      nxt_byte = byte_ff;
      nxt_ee = ee_ff;
      nxt_rd = rd_ff;
      nxt_ack = ack_ff;
      nxt_drv = drv_ff;
      nxt_ptr = ptr_ff;
      nxt_wr = 1'b0;
      nxt_rdq = 1'b0;
      if (on_bak_q || stop_ev) begin
         nxt_st = RTAD_IDLE;
         nxt_drv = 1'b0;
      end else if (start_ev) begin
         nxt_st = RTAD_RECV;
         nxt_bit = 4'h0;
         nxt_byte = 2'h0;
         nxt_drv = 1'b0;
      end else begin
         case (st_ff)
            RTAD_IDLE: begin
               nxt_drv = 1'b0;
            end
            RTAD_RECV: begin
               if (scl_rise) begin
                  nxt_sh = rx_byte;
                  nxt_bit = bit_ff + 4'h1;
                  if (bit_ff == 4'h7) begin
                     nxt_ack = 1'b0;
                     if (byte_ff == 2'h0) begin
                        nxt_ack = ctrl_ack;
                        nxt_ee = code_ee;
                        nxt_rd = rx_byte[0];
                     end else if (byte_ff == 2'h1) begin
                        nxt_ack = rtad_in_range(ee_ff, rx_byte);
                        nxt_ptr = rx_byte;
                     end else begin
                        nxt_ack = rtad_in_range(ee_ff, ptr_ff);
                        nxt_wr = nxt_ack;
                     end
                  end
               end else if (scl_fall && bit_ff == 4'h8) begin
                  nxt_st = ack_ff ? RTAD_ACK : RTAD_IDLE;
                  nxt_drv = ack_ff;
               end
            end
            RTAD_ACK: begin
               // hold low through the ninth pulse
               if (scl_fall) begin
                  nxt_bit = 4'h0;
                  nxt_drv = 1'b0;
                  if (byte_ff != 2'h3) begin
                     nxt_byte = byte_ff + 2'h1;
                  end
                  if (byte_ff >= 2'h2) begin
                     nxt_ptr = ptr_ff + 8'h1;
                  end
                  if (byte_ff == 2'h0 && rd_ff) begin
                     nxt_st = RTAD_SEND;
                     nxt_sh = mem_rdata;
                     nxt_drv = !mem_rdata[7];
                  end else begin
                     nxt_st = RTAD_RECV;
                  end
               end
            end
            RTAD_SEND: begin
               if (scl_fall) begin
                  nxt_bit = bit_ff + 4'h1;
                  nxt_sh = {sh_ff[6:0], 1'b1};
                  nxt_drv = (bit_ff == 4'h7) ? 1'b0 : !sh_ff[6];
                  if (bit_ff == 4'h7) begin
                     nxt_st = RTAD_MACK;
                     nxt_ptr = ptr_ff + 8'h1;
                  end
               end
            end
            RTAD_MACK: begin
               // master no-ack ends read; master acks
               if (scl_rise) begin
                  nxt_ack = !sda_q;
                  nxt_rdq = !sda_q;
               end else if (scl_fall) begin
                  nxt_bit = 4'h0;
                  nxt_st = ack_ff ? RTAD_SEND : RTAD_IDLE;
                  nxt_sh = mem_rdata;
                  nxt_drv = ack_ff && !mem_rdata[7];
               end
            end
            default: begin
               nxt_st = RTAD_IDLE;
               nxt_drv = 1'b0;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= RTAD_IDLE;
         sh_ff <= 8'h00;
         bit_ff <= 4'h0;
         byte_ff <= 2'h0;
         ee_ff <= 1'b0;
         rd_ff <= 1'b0;
         ack_ff <= 1'b0;
         drv_ff <= 1'b0;
         ptr_ff <= 8'h00;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         bit_ff <= nxt_bit;
         byte_ff <= nxt_byte;
         ee_ff <= nxt_ee;
         rd_ff <= nxt_rd;
         ack_ff <= nxt_ack;
         drv_ff <= nxt_drv;
         ptr_ff <= nxt_ptr;
      end
   end

   // Memory strobes and protect register; other storage lives outside and is never cleared here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_wr_ff <= 1'b0;
         mem_rd_ff <= 1'b0;
         mem_ee_ff <= 1'b0;
         mem_addr_ff <= 8'h00;
         mem_wdata_ff <= 8'h00;
         protect_ff <= RTAD_PROTECT_RST;
      end else begin
         mem_wr_ff <= nxt_wr && !prot_hit;
         mem_rd_ff <= nxt_rdq;
         mem_ee_ff <= ee_ff;
         mem_addr_ff <= nxt_ptr;
         if (nxt_wr) begin
            mem_wdata_ff <= rx_byte;
         end
         if (nxt_wr && prot_hit) begin
            protect_ff <= rx_byte;
         end
      end
   end

   // open drain: output low, enable drives
   assign link.sda_d_o = 1'b0;
   assign link.sda_d_oe = drv_ff;
endmodule : rtad_dev

// ==== rtad_link_if.sv ====
/*
 Two-wire link joining the master end and the device end.
 The line wires model the pull-ups here: a line is low whenever any party enables.
*/
`timescale 1ns/100ps
interface rtad_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_d_o;
   logic sda_d_oe;
   wire scl = !(scl_oe && !scl_o);
   wire sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
   modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                   input scl, input sda);
   modport device (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface : rtad_link_if

// ==== rtad_mst.sv ====
/*
 Master end: AHB-Lite command registers driving a two-wire bus master.
 Assumes one AHB-Lite master; only the SDA pin is sampled, through two flip-flops.
*/
`timescale 1ns/100ps
module rtad_mst (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   rtad_link_if.master link
);
   import rtad_pkg::*;

   typedef enum logic [3:0] {
      RTAD_M_IDLE = 4'b0001, RTAD_M_LOW = 4'b0010, RTAD_M_HIGH = 4'b0100, RTAD_M_DONE = 4'b1000
   } rtad_mstate_t;

   logic [1:0] sda_s_ff;
   logic [31:0] hrdata_ff;
   logic wr_pend_ff, rd_pend_ff;
   logic [7:0] ofs_ff;
   logic [2:0] cmd_ff;
   logic busy_ff, nack_ff, mack_ff;
   logic [7:0] tx_ff, rx_ff;
   logic [15:0] div_ff, cnt_ff;
   logic [3:0] bit_ff;
   logic [1:0] ph_ff;
   logic scl_ff, sda_ff;
   rtad_mstate_t st_ff;

   wire do_ph = busy_ff && cnt_ff == 16'h0000;
   wire take = hsel && hready && htrans[1];
   wire [2:0] new_cmd = hwdata[2:0];
   wire sda_in = sda_s_ff[1];

   // AHB-Lite: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // Address phase capture and read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         ofs_ff <= 8'h00;
         hrdata_ff <= 32'h00000000;
      end else begin
         wr_pend_ff <= take && hwrite;
         rd_pend_ff <= take && !hwrite;
         ofs_ff <= haddr;
         if (take && !hwrite) begin
            case (haddr)
               RTAD_OFS_STAT: hrdata_ff <= {29'h0, mack_ff, nack_ff, busy_ff};
               RTAD_OFS_RXD: hrdata_ff <= {24'h0, rx_ff};
               RTAD_OFS_TXD: hrdata_ff <= {24'h0, tx_ff};
               RTAD_OFS_DIV: hrdata_ff <= {16'h0, div_ff};
               default: hrdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // Data sampler
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sda_s_ff <= 2'h3;
      end else begin
         sda_s_ff <= {sda_s_ff[0], link.sda};
      end
   end

   // Bit engine: four phases per bit, clock derived from hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= RTAD_M_IDLE;
         busy_ff <= 1'b0;
         nack_ff <= 1'b0;
         mack_ff <= 1'b0;
         cmd_ff <= 3'h0;
         tx_ff <= 8'h00;
         rx_ff <= 8'h00;
         div_ff <= RTAD_DIV_RST;
         cnt_ff <= 16'h0000;
         bit_ff <= 4'h0;
         ph_ff <= 2'h0;
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         if (wr_pend_ff && ofs_ff == RTAD_OFS_TXD) begin
            tx_ff <= hwdata[7:0];
         end
         if (wr_pend_ff && ofs_ff == RTAD_OFS_DIV && !busy_ff) begin
            div_ff <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
         end
         if (wr_pend_ff && ofs_ff == RTAD_OFS_CTRL && !busy_ff) begin
            cmd_ff <= new_cmd;
            mack_ff <= hwdata[3];
            busy_ff <= new_cmd != 3'h0;
            cnt_ff <= div_ff;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
         end else if (busy_ff) begin
            cnt_ff <= (cnt_ff == 16'h0000) ? div_ff : cnt_ff - 16'h0001;
         end
         if (do_ph) begin
            ph_ff <= ph_ff + 2'h1;
            case (cmd_ff)
               RTAD_CMD_START: begin
                  case (ph_ff)
                     2'h0: begin sda_ff <= 1'b1; end
                     2'h1: begin scl_ff <= 1'b1; end
                     2'h2: begin sda_ff <= 1'b0; end
                     default: begin scl_ff <= 1'b0; busy_ff <= 1'b0; end
                  endcase
               end
               RTAD_CMD_STOP: begin
                  case (ph_ff)
                     2'h0: begin sda_ff <= 1'b0; end
                     2'h1: begin scl_ff <= 1'b1; end
                     2'h2: begin sda_ff <= 1'b1; end
                     default: begin busy_ff <= 1'b0; end
                  endcase
               end
               default: begin
                  // data set while SCL low; ninth pulse
                  case (ph_ff)
                     2'h0: begin
                        if (bit_ff == 4'h8) begin
                           // master ack or release on read
                           sda_ff <= (cmd_ff == RTAD_CMD_READ) ? !mack_ff : 1'b1;
                        end else begin
                           sda_ff <= (cmd_ff == RTAD_CMD_WRITE) ? tx_ff[3'(7 - bit_ff)] : 1'b1;
                        end
                     end
                     2'h1: begin scl_ff <= 1'b1; end
                     2'h2: begin
                        if (bit_ff == 4'h8) begin
                           nack_ff <= sda_in;
                        end else begin
                           rx_ff <= {rx_ff[6:0], sda_in};
                        end
                     end
                     default: begin
                        scl_ff <= 1'b0;
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff == 4'h8) begin
                           busy_ff <= 1'b0;
                        end
                     end
                  endcase
               end
            endcase
         end
         st_ff <= busy_ff ? RTAD_M_HIGH : RTAD_M_IDLE;
      end
   end

   // Open-drain pins: drive only when low
   assign link.scl_o = 1'b0;
   assign link.scl_oe = !scl_ff;
   assign link.sda_m_o = 1'b0;
   assign link.sda_m_oe = !sda_ff;
endmodule : rtad_mst

// ==== rtad_pkg.sv ====
/*
 Shared constants for the two-wire clock/calendar link: control codes,
 address windows and link timing.
 Assumes both ends import this package and share one system clock.
*/
// Behaviour
// - SDA falling while SCL high is Start.
// - SDA rising while SCL high is Stop.
// - SDA changes only while SCL low.
// - Master starts only on an idle bus.
// - Master opens with Start, closes with Stop.
// - Master sets the byte count; slave accepts any; the device refuses write data bytes once the pointer passes the window end.
// - Addressed receiver acknowledges every byte; the device refuses a write data byte whose pointer is outside the window.
// - Master gives a ninth pulse for acknowledge.
// - Acknowledge holds SDA low through SCL high.
// - Read ends on master no-ack; slave releases SDA.
// - EEPROM control byte refused while programming.
// - Interface ignores the bus on backup supply.
// - Upper control nibble 1010 EEPROM, 1101 clock/SRAM.
// - Three chip-select bits must be ones.
// - Control bit zero: one reads, zero writes.
// - Matching address is acknowledged, then read/write.
// - Unimplemented address byte gets no acknowledge.
// - Clock 0x00-0x1F, SRAM 0x20-0x5F.
// - EEPROM 0x00-0x7F, 0xF0-0xF7, protect 0xFF.
// - Clock window split into five groups.
// - Clock and SRAM contents kept on backup.
// - Device only pulls SDA low or releases.
package rtad_pkg;
   localparam logic [3:0] RTAD_CODE_EE = 4'hA;
   localparam logic [3:0] RTAD_CODE_RT = 4'hD;
   localparam logic [2:0] RTAD_CHIP_SEL = 3'h7;
   localparam logic [7:0] RTAD_RT_LAST = 8'h5F;
   localparam logic [7:0] RTAD_SRAM_BASE = 8'h20;
   localparam logic [7:0] RTAD_TIME_BASE = 8'h00;
   localparam logic [7:0] RTAD_CFG_BASE = 8'h07;
   localparam logic [7:0] RTAD_ALM0_BASE = 8'h0A;
   localparam logic [7:0] RTAD_ALM1_BASE = 8'h11;
   localparam logic [7:0] RTAD_STAMP_BASE = 8'h18;
   localparam logic [7:0] RTAD_EE_LAST = 8'h7F;
   localparam logic [7:0] RTAD_PROT_BASE = 8'hF0;
   localparam logic [7:0] RTAD_PROT_LAST = 8'hF7;
   localparam logic [7:0] RTAD_PROTECT_REG = 8'hFF;
   localparam logic [7:0] RTAD_PROTECT_RST = 8'h00;
   // Master command registers (word offsets on the AHB-Lite slave)
   localparam logic [7:0] RTAD_OFS_CTRL = 8'h00;
   localparam logic [7:0] RTAD_OFS_STAT = 8'h04;
   localparam logic [7:0] RTAD_OFS_TXD = 8'h08;
   localparam logic [7:0] RTAD_OFS_RXD = 8'h0C;
   localparam logic [7:0] RTAD_OFS_DIV = 8'h10;
   // Command codes written into the control register
   localparam logic [2:0] RTAD_CMD_START = 3'h1;
   localparam logic [2:0] RTAD_CMD_WRITE = 3'h2;
   localparam logic [2:0] RTAD_CMD_READ = 3'h3;
   localparam logic [2:0] RTAD_CMD_STOP = 3'h4;
   // Link timing: quarter bit period 80 ns at a 40 ns clock
   localparam int RTAD_CLK_NS = 40;
   localparam int RTAD_QTR_NS = 80;
   localparam int RTAD_QTR_CYC = (RTAD_QTR_NS + RTAD_CLK_NS - 1) / RTAD_CLK_NS;
   localparam logic [15:0] RTAD_DIV_RST = 16'(RTAD_QTR_CYC);
endpackage : rtad_pkg

// ==== tb.sv ====
/*
 Self-checking bench: AHB-Lite master runs the master end, the device end
 faces it on one link, byte memories stand behind the device port.
 Assumes hready follows hreadyout and the divider keeps its reset value.
*/
`timescale 1ns/100ps
module tb;
   import rtad_pkg::*;
   logic hclk, hresetn, hwrite, on_backup, ee_busy, hreadyout, hresp, dev_wr, dev_ee, dev_rd;
   logic [7:0] haddr, dev_addr, dev_wdata, protect, mem_rdata;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata, st;
   logic [7:0] rt_mem [256];
   logic [7:0] ee_mem [256];
   logic [7:0] alist [13] = '{8'h00, 8'h1F, 8'h20, 8'h5F, 8'h60, 8'h7F, 8'h80,
                              8'hEF, 8'hF0, 8'hF7, 8'hF8, 8'hFE, 8'hFF};
   logic [7:0] clist [6] = '{8'hDE, 8'hAE, 8'hBE, 8'hDC, 8'hAA, 8'h5E};
   logic [7:0] glist [5] = '{RTAD_TIME_BASE, RTAD_CFG_BASE, RTAD_ALM0_BASE, RTAD_ALM1_BASE,
                             RTAD_STAMP_BASE};
   int fail_count, cmp_count, cyc, i, rd_cnt;
   wire hready = hreadyout;
   rtad_link_if rtad_link_if_inst ();
   rtad_mst rtad_mst_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(rtad_link_if_inst));
   rtad_dev rtad_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(rtad_link_if_inst),
      .on_backup(on_backup), .ee_busy(ee_busy), .mem_wr_ff(dev_wr), .mem_rd_ff(dev_rd),
      .mem_ee_ff(dev_ee), .mem_addr_ff(dev_addr), .mem_wdata_ff(dev_wdata),
      .mem_rdata(mem_rdata), .protect_ff(protect));
   rtad_checker rtad_checker_inst (.hclk(hclk), .hresetn(hresetn),
      .scl_o(rtad_link_if_inst.scl_o), .scl_oe(rtad_link_if_inst.scl_oe),
      .sda_m_o(rtad_link_if_inst.sda_m_o), .sda_m_oe(rtad_link_if_inst.sda_m_oe),
      .sda_d_o(rtad_link_if_inst.sda_d_o), .sda_d_oe(rtad_link_if_inst.sda_d_oe),
      .scl(rtad_link_if_inst.scl), .sda(rtad_link_if_inst.sda));
   // Byte memories behind the device port
   assign mem_rdata = dev_ee ? ee_mem[dev_addr] : rt_mem[dev_addr];
   always @(posedge hclk) begin
      if (dev_wr === 1'b1 && dev_ee === 1'b1) ee_mem[dev_addr] <= dev_wdata;
      else if (dev_wr === 1'b1) rt_mem[dev_addr] <= dev_wdata;
      if (dev_rd === 1'b1) rd_cnt <= rd_cnt + 1;
   end
   // Clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Hang guard
   initial begin
      cyc = 0;
      forever begin
         @(posedge hclk);
         cyc++;
         if (cyc >= 60000) begin
            fail_count++;
            end_sim();
         end
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One single AHB-Lite transfer
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : ahb
   // Issue a command and poll until idle
   task automatic cmd(input logic [7:0] c, output logic [31:0] s);
      logic [31:0] d;
      ahb(1'b1, RTAD_OFS_CTRL, {24'h0, c}, d);
      s = 32'h1;
      while (s[0] !== 1'b0) ahb(1'b0, RTAD_OFS_STAT, 32'h0, s);
   endtask : cmd
   task automatic cond(input logic [2:0] c);
      logic [31:0] s;
      cmd({5'h0, c}, s);
   endtask : cond
   task automatic wbyte(input logic [7:0] b, input logic nk);
      logic [31:0] s;
      ahb(1'b1, RTAD_OFS_TXD, {24'h0, b}, s);
      cmd({5'h0, RTAD_CMD_WRITE}, s);
      chk({31'h0, s[1]}, {31'h0, nk});
   endtask : wbyte
   task automatic rbyte(input logic ack, input logic [7:0] exp);
      logic [31:0] s;
      cmd({4'h0, ack, RTAD_CMD_READ}, s);
      ahb(1'b0, RTAD_OFS_RXD, 32'h0, s);
      chk({24'h0, s[7:0]}, {24'h0, exp});
   endtask : rbyte
   // Expected refusal of a control byte or an address byte
   function automatic logic ctrl_nack(input logic [7:0] c);
      return !((c[7:4] == 4'hD || c[7:4] == 4'hA) && c[3:1] == 3'h7);
   endfunction : ctrl_nack
   function automatic logic addr_nack(input logic ee, input logic [7:0] a);
      if (ee) return !(a <= 8'h7F || (a >= 8'hF0 && a <= 8'hF7) || a == 8'hFF);
      return a > 8'h5F;
   endfunction : addr_nack
   task end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      hresetn = 1'b0;
      htrans = 2'h0;
      haddr = 8'h00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      on_backup = 1'b0;
      ee_busy = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      chk({24'h0, protect}, 32'h0);
      ahb(1'b0, RTAD_OFS_DIV, 32'h0, st);
      chk(st, 32'h2);
      ahb(1'b0, 8'h20, 32'h0, st);
      chk(st, 32'h0);
      // Write run over the top of SRAM, third byte out of range
      cond(RTAD_CMD_START);
      wbyte(8'hDE, 1'b0);
      wbyte(8'h5E, 1'b0);
      wbyte(8'h11, 1'b0);
      wbyte(8'h22, 1'b0);
      wbyte(8'h33, 1'b1);
      cond(RTAD_CMD_STOP);
      chk({24'h0, rt_mem[8'h5E]}, 32'h11);
      chk({24'h0, rt_mem[8'h5F]}, 32'h22);
      // Read back with repeated start, last byte not acknowledged
      cond(RTAD_CMD_START);
      wbyte(8'hDE, 1'b0);
      wbyte(8'h5E, 1'b0);
      cond(RTAD_CMD_START);
      wbyte(8'hDF, 1'b0);
      rbyte(1'b1, 8'h11);
      rbyte(1'b0, 8'h22);
      cond(RTAD_CMD_STOP);
      chk(rd_cnt, 32'h1);
      // Control byte codes and chip-select bits
      for (i = 0; i < 6; i++) begin
         cond(RTAD_CMD_START);
         wbyte(clist[i], ctrl_nack(clist[i]));
         cond(RTAD_CMD_STOP);
      end
      // Address windows of both spaces
      for (i = 0; i < 26; i++) begin
         cond(RTAD_CMD_START);
         wbyte((i < 13) ? 8'hDE : 8'hAE, 1'b0);
         wbyte(alist[i % 13], addr_nack(i >= 13, alist[i % 13]));
         cond(RTAD_CMD_STOP);
      end
      // Each clock register group takes a write at its base
      for (i = 0; i < 5; i++) begin
         cond(RTAD_CMD_START);
         wbyte(8'hDE, 1'b0);
         wbyte(glist[i], 1'b0);
         wbyte(8'hC0 + 8'(i), 1'b0);
         cond(RTAD_CMD_STOP);
         chk({24'h0, rt_mem[glist[i]]}, {24'h0, 8'hC0 + 8'(i)});
      end
      // Protect register and an EEPROM data byte
      cond(RTAD_CMD_START);
      wbyte(8'hAE, 1'b0);
      wbyte(8'hFF, 1'b0);
      wbyte(8'h5A, 1'b0);
      cond(RTAD_CMD_START);
      wbyte(8'hAE, 1'b0);
      wbyte(8'h7F, 1'b0);
      wbyte(8'h3C, 1'b0);
      cond(RTAD_CMD_STOP);
      chk({24'h0, protect}, 32'h5A);
      chk({24'h0, ee_mem[8'h7F]}, 32'h3C);
      // EEPROM programming blocks only the EEPROM space
      @(posedge hclk) ee_busy <= 1'b1;
      cond(RTAD_CMD_START);
      wbyte(8'hAE, 1'b1);
      cond(RTAD_CMD_STOP);
      cond(RTAD_CMD_START);
      wbyte(8'hDE, 1'b0);
      cond(RTAD_CMD_STOP);
      @(posedge hclk) ee_busy <= 1'b0;
      // Backup supply silences the interface
      @(posedge hclk) on_backup <= 1'b1;
      cond(RTAD_CMD_START);
      wbyte(8'hDE, 1'b1);
      cond(RTAD_CMD_STOP);
      @(posedge hclk) on_backup <= 1'b0;
      cond(RTAD_CMD_START);
      wbyte(8'hDE, 1'b0);
      cond(RTAD_CMD_STOP);
      end_sim();
   end
endmodule : tb
